/* File: design/dag_defs.vh */
// constants for the dma address generation and status block
// assumes an apb slave on pclk; included by the single design file
// Function
// RULE1 - non-3d: upper bits destination, lower source
// RULE2 - one shared counter, offsets may be shared
// RULE3 - codes 000-011: 2d with offset 0-3
// RULE4 - code 100: constant address, single counter
// RULE5 - code 101: increment by one, single counter
// RULE6 - differing counter modes force split mode
// RULE7 - single 24-bit count or two 12-bit halves
// RULE8 - 3d: mode, side select, counter mode fields
// RULE9 - 3d codes 110/111 use offset pairs
// RULE10 - side bit picks which side is 3d
// RULE11 - counter sections per counter-mode code, 11 reserved
// RULE12 - 3d steps low, offset1, middle, offset2, high
// RULE13 - 2d uses one offset, 3d uses two
// RULE14 - other side may use any offset choice
// RULE15 - four 24-bit read/write offset registers
// RULE16 - 24-bit read-only status, upper bits zero
// RULE17 - active channel in bits 11 to 9
// RULE18 - active bit set while transfer runs
// RULE19 - done flag on last word, cleared on enable
// RULE20 - reserved codes give no defined stepping
`ifndef DAG_DEFS_VH
`define DAG_DEFS_VH
// byte addresses of the registers on apb
`define DAG_ADDR_OFS0     12'h000
`define DAG_ADDR_OFS1     12'h004
`define DAG_ADDR_OFS2     12'h008
`define DAG_ADDR_OFS3     12'h00C
`define DAG_ADDR_STATUS   12'h010
`define DAG_ADDR_CTRL     12'h014
`define DAG_ADDR_COUNT    12'h018
`define DAG_ADDR_SRC      12'h01C
`define DAG_ADDR_DST      12'h020
`define DAG_ADDR_CHAN     12'h024
// control register fields
`define DAG_CTRL_MODE_LSB 0
`define DAG_CTRL_3D_BIT   6
`define DAG_CTRL_EN_BIT   7
// status register fields
`define DAG_ST_DONE_LSB   0
`define DAG_ST_ACT_BIT    8
`define DAG_ST_CH_LSB     9
// per-side address modes after decode
`define DAG_AM_2D         3'h0
`define DAG_AM_NOUPD      3'h1
`define DAG_AM_INC        3'h2
`define DAG_AM_3D         3'h3
`define DAG_AM_BAD        3'h4
// counter modes
`define DAG_CM_A          3'h0
`define DAG_CM_B          3'h1
`define DAG_CM_C          3'h2
`define DAG_CM_D          3'h3
`define DAG_CM_E          3'h4
`define DAG_CM_BAD        3'h5
`define DAG_DONE_RESET    6'h3F
`endif

/* File: design/dag_core.v */
// dma address generation and status: decodes the address-mode field,
// splits the transfer counter into sections, steps two addresses
// assumes an apb master on pclk; one word moves per step strobe
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "dag_defs.vh"
module dag_core #(
	parameter AW = 24 // address and counter width
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire        word_step,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [23:0] src_addr,
	output reg  [23:0] dst_addr,
	output reg         transfer_active_bit,
	output reg         block_done_pulse,
	output reg         mode_fault
);

	// decoded side mode from a three-bit code
	function [2:0] side_mode;
		input [2:0] code;
		begin
			case (code)
				3'h0, 3'h1, 3'h2, 3'h3: side_mode = `DAG_AM_2D;
				3'h4:                   side_mode = `DAG_AM_NOUPD;
				3'h5:                   side_mode = `DAG_AM_INC;
				default:                side_mode = `DAG_AM_BAD;
			endcase
		end
	endfunction

	reg  [23:0] offset_reg_zero;     // offset 0
	reg  [23:0] offset_reg_one;      // offset 1
	reg  [23:0] offset_reg_two;      // offset 2
	reg  [23:0] offset_reg_three;    // offset 3
	reg  [5:0]  address_mode_field;  // mode code
	reg         three_dim_flag;      // 3d selection
	reg         chan_enable;         // channel enable
	reg  [2:0]  active_channel_field; // channel number of this context
	reg  [23:0] transfer_counter;    // programmed count
	reg  [23:0] src_base;            // programmed source start
	reg  [23:0] dst_base;            // programmed destination start
	reg  [5:0]  channel_done_flags;  // per-channel done
	reg  [11:0] cnt_lo;              // inner section position
	reg  [11:0] cnt_mid;             // middle section position
	reg  [11:0] cnt_hi;              // outer section position
	reg  [23:0] cnt_single;          // single-counter position

	// decoded modes and offsets
	reg  [2:0]  src_mode;
	reg  [2:0]  dst_mode;
	reg  [2:0]  cnt_mode;
	reg  [23:0] src_off1;
	reg  [23:0] src_off2;
	reg  [23:0] dst_off1;
	reg  [23:0] dst_off2;
	reg  [11:0] lim_lo;
	reg  [11:0] lim_mid;
	reg  [11:0] lim_hi;

	wire        apb_wr = psel & penable & pwrite & pready;
	wire        apb_rd = psel & ~penable & ~pwrite;
	wire        en_rise = apb_wr & (paddr == `DAG_ADDR_CTRL) & pwdata[`DAG_CTRL_EN_BIT];

	// offset picked by a two-bit index
	function [23:0] pick;
		input [1:0]  idx;
		input [23:0] o0;
		input [23:0] o1;
		input [23:0] o2;
		input [23:0] o3;
		begin
			case (idx)
				2'h0:    pick = o0;
				2'h1:    pick = o1;
				2'h2:    pick = o2;
				default: pick = o3;
			endcase
		end
	endfunction

	// mode decode for both sides
	always @* begin
		src_off2 = 24'h000000;
		dst_off2 = 24'h000000;
		if (!three_dim_flag) begin
			dst_mode = side_mode(address_mode_field[5:3]); // RULE1
			src_mode = side_mode(address_mode_field[2:0]); // RULE1
			// one offset per 2d side, possibly the same register
			dst_off1 = pick(address_mode_field[4:3], offset_reg_zero, offset_reg_one,
				offset_reg_two, offset_reg_three); // RULE2
			src_off1 = pick(address_mode_field[1:0], offset_reg_zero, offset_reg_one,
				offset_reg_two, offset_reg_three); // RULE3
			// mixed single and split codes run split
			if (dst_mode == `DAG_AM_BAD || src_mode == `DAG_AM_BAD)
				cnt_mode = `DAG_CM_BAD; // RULE20
			else if (dst_mode == `DAG_AM_2D || src_mode == `DAG_AM_2D)
				cnt_mode = `DAG_CM_B; // RULE6
			else
				cnt_mode = `DAG_CM_A; // RULE4 RULE5
		end else begin
			// upper bits give the non-3d side its mode
			case (address_mode_field[5:3])
				3'h6, 3'h7: dst_mode = `DAG_AM_3D; // RULE9
				default:    dst_mode = side_mode(address_mode_field[5:3]); // RULE8
			endcase
			src_mode = dst_mode;
			dst_off1 = address_mode_field[5:3] == 3'h6 ? offset_reg_zero :
				address_mode_field[5:3] == 3'h7 ? offset_reg_two :
				pick(address_mode_field[4:3], offset_reg_zero, offset_reg_one,
				offset_reg_two, offset_reg_three); // RULE14
			dst_off2 = address_mode_field[5:3] == 3'h6 ? offset_reg_one : offset_reg_three;
			src_off1 = dst_off1;
			src_off2 = dst_off2;
			if (!address_mode_field[2]) begin
				src_mode = `DAG_AM_3D; // RULE10
				src_off1 = offset_reg_zero; // RULE13
				src_off2 = offset_reg_one;
			end else begin
				dst_mode = `DAG_AM_3D; // RULE10
				dst_off1 = offset_reg_two; // RULE13
				dst_off2 = offset_reg_three;
			end
			case (address_mode_field[1:0])
				2'h0:    cnt_mode = `DAG_CM_C; // RULE11
				2'h1:    cnt_mode = `DAG_CM_D;
				2'h2:    cnt_mode = `DAG_CM_E;
				default: cnt_mode = `DAG_CM_BAD; // RULE20
			endcase
		end
	end

	// counter section limits for the chosen layout
	always @* begin
		lim_lo  = 12'h000;
		lim_mid = 12'h000;
		lim_hi  = 12'h000;
		case (cnt_mode)
			`DAG_CM_B: begin
				lim_hi = transfer_counter[23:12]; // RULE7
				lim_lo = transfer_counter[11:0];
			end
			`DAG_CM_C: begin
				lim_hi  = transfer_counter[23:12]; // RULE11
				lim_mid = {6'h00, transfer_counter[11:6]};
				lim_lo  = {6'h00, transfer_counter[5:0]};
			end
			`DAG_CM_D: begin
				lim_hi  = {6'h00, transfer_counter[23:18]};
				lim_mid = transfer_counter[17:6];
				lim_lo  = {6'h00, transfer_counter[5:0]};
			end
			`DAG_CM_E: begin
				lim_hi  = {6'h00, transfer_counter[23:18]};
				lim_mid = {6'h00, transfer_counter[17:12]};
				lim_lo  = transfer_counter[11:0];
			end
			default: begin
				lim_lo = 12'h000;
			end
		endcase
	end

	// where each section sits in its loop
	wire lo_end  = (cnt_lo == lim_lo);
	wire mid_end = (cnt_mid == lim_mid);
	wire hi_end  = (cnt_hi == lim_hi);
	wire is_3d   = (cnt_mode == `DAG_CM_C) || (cnt_mode == `DAG_CM_D) ||
		(cnt_mode == `DAG_CM_E);
	wire last_word = (cnt_mode == `DAG_CM_A) ? (cnt_single == transfer_counter) :
		is_3d ? (lo_end & mid_end & hi_end) : (lo_end & hi_end); // RULE7
	wire bad = (cnt_mode == `DAG_CM_BAD) || (src_mode == `DAG_AM_BAD) ||
		(dst_mode == `DAG_AM_BAD);
	wire step = word_step & chan_enable & transfer_active_bit & ~bad;

	// next address for one side given its mode and offsets
	function [23:0] next_addr;
		input [2:0]  mode;
		input [23:0] cur;
		input [23:0] o1;
		input [23:0] o2;
		input        lo_wrap;
		input        mid_wrap;
		input        split3;
		begin
			case (mode)
				`DAG_AM_NOUPD: next_addr = cur; // RULE4
				`DAG_AM_INC:   next_addr = cur + 24'h000001; // RULE5
				`DAG_AM_2D:    next_addr = lo_wrap ? cur + o1 : cur + 24'h000001; // RULE3
				`DAG_AM_3D:    next_addr = (lo_wrap & mid_wrap & split3) ? cur + o2 :
					lo_wrap ? cur + o1 : cur + 24'h000001; // RULE12
				default:       next_addr = cur; // RULE20
			endcase
		end
	endfunction

	// apb slave: zero-wait access, unmapped addresses fault
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= apb_rd | (psel & ~penable & pwrite);
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				case (paddr)
					`DAG_ADDR_OFS0:   prdata <= {8'h00, offset_reg_zero}; // RULE15
					`DAG_ADDR_OFS1:   prdata <= {8'h00, offset_reg_one};
					`DAG_ADDR_OFS2:   prdata <= {8'h00, offset_reg_two};
					`DAG_ADDR_OFS3:   prdata <= {8'h00, offset_reg_three};
					`DAG_ADDR_STATUS: prdata <= {20'h00000, active_channel_field,
						transfer_active_bit, 2'h0, channel_done_flags}; // RULE16 RULE17
					`DAG_ADDR_CTRL:   prdata <= {24'h000000, chan_enable, three_dim_flag,
						address_mode_field};
					`DAG_ADDR_COUNT:  prdata <= {8'h00, transfer_counter};
					`DAG_ADDR_SRC:    prdata <= {8'h00, src_addr};
					`DAG_ADDR_DST:    prdata <= {8'h00, dst_addr};
					`DAG_ADDR_CHAN:   prdata <= {29'h00000000, active_channel_field};
					default: begin
						prdata  <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// software registers; status is never written
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_reg_zero      <= 24'h000000;
			offset_reg_one       <= 24'h000000;
			offset_reg_two       <= 24'h000000;
			offset_reg_three     <= 24'h000000;
			address_mode_field   <= 6'h00;
			three_dim_flag       <= 1'b0;
			transfer_counter     <= 24'h000000;
			src_base             <= 24'h000000;
			dst_base             <= 24'h000000;
			active_channel_field <= 3'h0;
		end else if (apb_wr) begin
			case (paddr)
				`DAG_ADDR_OFS0:  offset_reg_zero  <= pwdata[23:0]; // RULE15
				`DAG_ADDR_OFS1:  offset_reg_one   <= pwdata[23:0];
				`DAG_ADDR_OFS2:  offset_reg_two   <= pwdata[23:0];
				`DAG_ADDR_OFS3:  offset_reg_three <= pwdata[23:0];
				`DAG_ADDR_CTRL: begin
					address_mode_field <= pwdata[5:0];
					three_dim_flag     <= pwdata[`DAG_CTRL_3D_BIT];
				end
				`DAG_ADDR_COUNT: transfer_counter <= pwdata[23:0];
				`DAG_ADDR_SRC:   src_base <= pwdata[23:0];
				`DAG_ADDR_DST:   dst_base <= pwdata[23:0];
				`DAG_ADDR_CHAN: begin
					// channel 6 and 7 codes are reserved; clamp
					active_channel_field <= pwdata[2:0] > 3'h5 ? 3'h5 : pwdata[2:0];
				end
				default: begin
					active_channel_field <= active_channel_field;
				end
			endcase
		end
	end

	// transfer engine: sections count up to their limits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_enable         <= 1'b0;
			transfer_active_bit <= 1'b0;
			channel_done_flags  <= `DAG_DONE_RESET;
			cnt_lo              <= 12'h000;
			cnt_mid             <= 12'h000;
			cnt_hi              <= 12'h000;
			cnt_single          <= 24'h000000;
			src_addr            <= 24'h000000;
			dst_addr            <= 24'h000000;
			block_done_pulse    <= 1'b0;
			mode_fault          <= 1'b0;
		end else begin
			block_done_pulse <= 1'b0;
			mode_fault       <= bad & chan_enable; // RULE20
			if (apb_wr && paddr == `DAG_ADDR_CTRL) begin
				chan_enable         <= pwdata[`DAG_CTRL_EN_BIT];
				transfer_active_bit <= pwdata[`DAG_CTRL_EN_BIT]; // RULE18
				if (en_rise) begin
					// new block starts from the programmed bases
					// a last word landing in the same cycle keeps its flag set
					channel_done_flags[active_channel_field] <= step & last_word; // RULE19
					cnt_lo     <= 12'h000;
					cnt_mid    <= 12'h000;
					cnt_hi     <= 12'h000;
					cnt_single <= 24'h000000;
					src_addr   <= src_base;
					dst_addr   <= dst_base;
				end
			end else if (step) begin
				src_addr <= next_addr(src_mode, src_addr, src_off1, src_off2,
					lo_end, mid_end, is_3d); // RULE2
				dst_addr <= next_addr(dst_mode, dst_addr, dst_off1, dst_off2,
					lo_end, mid_end, is_3d);
				cnt_single <= cnt_single + 24'h000001;
				cnt_lo <= lo_end ? 12'h000 : cnt_lo + 12'h001;
				if (lo_end) begin
					cnt_mid <= (mid_end | ~is_3d) ? 12'h000 : cnt_mid + 12'h001;
					if (mid_end | ~is_3d)
						cnt_hi <= cnt_hi + 12'h001;
				end
				if (last_word) begin
					// block complete: stop and flag this channel
					channel_done_flags[active_channel_field] <= 1'b1; // RULE19
					chan_enable         <= 1'b0;
					transfer_active_bit <= 1'b0; // RULE18
					block_done_pulse    <= 1'b1;
				end
			end
		end
	end

endmodule

/* File: bench/dag_core_properties.sv */
// checker for the dma address generation and status block
// assumes the dag_core ports only; one pclk domain, presetn low resets
`timescale 1ns/1ps
`include "dag_defs.vh"
module dag_core_props (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic        word_step,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic [23:0] src_addr,
	input logic [23:0] dst_addr,
	input logic        transfer_active_bit,
	input logic        block_done_pulse,
	input logic        mode_fault
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup cycle, any write, status read answer
	wire setup = psel && !penable;
	wire wr    = psel && pwrite;
	wire rd_st = pready && psel && !pwrite && paddr == `DAG_ADDR_STATUS;
	chk_ready_next: assert property (setup |=> pready)
		else $error("no answer after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("answer held too long");
	chk_err_unmapped: assert property (setup && paddr > 12'h024 |=> pslverr)
		else $error("unmapped access not refused");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	chk_done_pulse: assert property (block_done_pulse |-> $past(word_step) ##1 !block_done_pulse)
		else $error("done pulse not tied to last word");
	chk_idle_hold: assert property (!word_step && !wr |=> $stable(src_addr) && $stable(dst_addr))
		else $error("address moved without a word");
	chk_fault_hold: assert property (mode_fault && word_step && !wr |=>
		$stable(src_addr) && $stable(dst_addr) && !block_done_pulse)
		else $error("reserved code stepped");
	chk_status_top: assert property (rd_st |-> prdata[31:12] == 20'h0)
		else $error("status upper bits not zero");
	chk_status_act: assert property (rd_st |-> prdata[8] == $past(transfer_active_bit))
		else $error("activity bit mismatch");
	chk_status_chan: assert property (rd_st && prdata[8] |-> prdata[11:9] <= 3'h5)
		else $error("active channel out of range");
	// main scenarios reached
	cover property (block_done_pulse);
	cover property (pslverr);
	cover property (mode_fault);
endmodule
bind dag_core dag_core_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.word_step, .prdata, .pready, .pslverr, .src_addr, .dst_addr, .transfer_active_bit,
	.block_done_pulse, .mode_fault);

/* File: bench/dag_mem_model.sv */
// memory side model: moves one word per request after a gap
// assumes req is a one-cycle pulse and gap is at least one
`timescale 1ns/1ps
module dag_mem_model (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       req,
	input  logic [3:0] gap,
	output logic       word_step
);
	logic [3:0] cnt; // cycles left before the word lands
	// one strobe moves both sides at once, slow or prompt by gap
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			word_step <= 1'b0;
		end else begin
			word_step <= (cnt == 4'h1);
			if (req)
				cnt <= gap;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule

/* File: bench/tb_dma_address_generation_status.sv */
// testbench for the dma address generation and status block
// assumes dag_core with apb at 10 MHz and the memory model at its far side
`timescale 1ns/1ps
`include "dag_defs.vh"
module tb_dma_address_generation_status;
	typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} dag_row_t;
	logic        pclk, presetn, psel, penable, pwrite, word_step, req, er;
	logic        pready, pslverr, transfer_active_bit, block_done_pulse, mode_fault;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] src_addr, dst_addr;
	logic [3:0]  gap;
	integer      fail_count, n_tests, i;
	dag_row_t    rows [12]; // access, expected read and error
	dag_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .word_step,
		.prdata, .pready, .pslverr, .src_addr, .dst_addr, .transfer_active_bit,
		.block_done_pulse, .mode_fault);
	dag_mem_model mem_u (.pclk, .presetn, .req, .gap, .word_step);
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	task conclude;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		integer k;
		@(posedge pclk);
		psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k = k + 1;
		end while (pready !== 1'b1 && k < 16);
		chk(pready, 1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// ask the far side for one word and wait for it to land
	task step(input logic [3:0] g);
		integer k;
		@(posedge pclk);
		gap <= g; req <= 1;
		@(posedge pclk);
		req <= 0;
		k = 0;
		while (word_step !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k = k + 1;
		end
		@(posedge pclk);
	endtask
	// program a block, step it through, last word ends it
	task run(input logic [7:0] c, input logic [23:0] n, input logic [23:0] es[$],
		input logic [23:0] ed[$]);
		integer j;
		apb(`DAG_ADDR_SRC, 1, 32'h100);
		apb(`DAG_ADDR_DST, 1, 32'h200);
		apb(`DAG_ADDR_COUNT, 1, {8'h00, n});
		apb(`DAG_ADDR_CTRL, 1, {24'h0, c});
		apb(`DAG_ADDR_STATUS, 0, 32'h0);
		chk(rd[5:0], 6'h37);
		chk(rd[11:8], 4'h7);
		chk(transfer_active_bit, 1);
		chk(mode_fault, 0);
		for (j = 0; j <= es.size(); j++) begin
			step(j[0] ? 4'h5 : 4'h1);
			chk(block_done_pulse, j == es.size());
			if (j < es.size()) begin
				chk(src_addr, es[j]);
				chk(dst_addr, ed[j]);
			end
		end
		apb(`DAG_ADDR_STATUS, 0, 32'h0);
		chk(rd & 32'hFFFFF1FF, 32'h3F);
		chk(transfer_active_bit, 0);
		$display("test block %h done", c);
	endtask
	initial begin
		psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		req = 0; gap = 1; presetn = 0; fail_count = 0; n_tests = 0;
		rows = '{'{`DAG_ADDR_STATUS, 1'b0, 32'h0, 32'h3F, 1'b0},
			'{`DAG_ADDR_OFS0, 1'b1, 32'hAA123456, 32'h0, 1'b0},
			'{`DAG_ADDR_OFS0, 1'b0, 32'h0, 32'h123456, 1'b0},
			'{`DAG_ADDR_OFS1, 1'b1, 32'h654321, 32'h0, 1'b0},
			'{`DAG_ADDR_OFS1, 1'b0, 32'h0, 32'h654321, 1'b0},
			'{`DAG_ADDR_OFS2, 1'b1, 32'h10, 32'h0, 1'b0},
			'{`DAG_ADDR_OFS2, 1'b0, 32'h0, 32'h10, 1'b0},
			'{`DAG_ADDR_OFS3, 1'b1, 32'hFFFFFF, 32'h0, 1'b0},
			'{`DAG_ADDR_OFS3, 1'b0, 32'h0, 32'hFFFFFF, 1'b0},
			'{`DAG_ADDR_STATUS, 1'b1, 32'hFFFFFF, 32'h0, 1'b0},
			'{`DAG_ADDR_STATUS, 1'b0, 32'h0, 32'h3F, 1'b0},
			'{12'h028, 1'b0, 32'h0, 32'h0, 1'b1}};
		repeat (3) @(posedge pclk);
		presetn <= 1;
		for (i = 0; i < 12; i++) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w)
				chk(rd, rows[i].x);
			chk(er, rows[i].e);
		end
		$display("test registers done");
		apb(`DAG_ADDR_CHAN, 1, 32'h3);
		apb(`DAG_ADDR_OFS0, 1, 32'h10);
		apb(`DAG_ADDR_OFS1, 1, 32'h100);
		run(8'hA5, 24'h2, '{24'h101, 24'h102}, '{24'h200, 24'h200});
		run(8'hA8, 24'h001001, '{24'h101, 24'h111, 24'h112}, '{24'h201, 24'h202, 24'h203});
		run(8'hF0, 24'h001041, '{24'h101, 24'h111, 24'h112, 24'h212, 24'h213, 24'h223, 24'h224},
			'{24'h201, 24'h211, 24'h212, 24'h312, 24'h313, 24'h323, 24'h324});
		// reserved address mode, then reserved counter mode
		apb(`DAG_ADDR_CTRL, 1, 32'hB6);
		step(4'h1);
		chk(src_addr, 24'h100);
		chk(mode_fault, 1);
		apb(`DAG_ADDR_CTRL, 1, 32'hC3);
		step(4'h1);
		chk(dst_addr, 24'h200);
		chk(mode_fault, 1);
		$display("test reserved done");
		// reset in mid-run restores the status
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(`DAG_ADDR_STATUS, 0, 32'h0);
		chk(rd, 32'h3F);
		chk(mode_fault, 0);
		$display("test reset done");
		conclude;
	end
	// hang guard, far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count = fail_count + 1;
		conclude;
	end
endmodule
